// ===== pkg/fwdp_pkg.sv
package fwdp_pkg;

  // ***********************************************************
  // register indices (byte address is four times the index)
  // ***********************************************************
  localparam logic [7:0] FWDP_IDX_P0_LOW  = 8'h82;
  localparam logic [7:0] FWDP_IDX_P0_HIGH = 8'h83;
  localparam logic [7:0] FWDP_IDX_P1_LOW  = 8'h84;
  localparam logic [7:0] FWDP_IDX_P1_HIGH = 8'h85;
  localparam logic [7:0] FWDP_IDX_PCTRL   = 8'h86;
  localparam logic [7:0] FWDP_IDX_WAIT    = 8'h92;
  localparam logic [7:0] FWDP_IDX_P0_TOP  = 8'h93;
  localparam logic [7:0] FWDP_IDX_P1_TOP  = 8'h95;

  // ***********************************************************
  // bus geometry
  // ***********************************************************
  localparam int unsigned FWDP_ADDR_W  = 10;
  localparam int unsigned FWDP_DATA_W  = 32;

  // ***********************************************************
  // values after reset
  // ***********************************************************
  localparam logic [7:0] FWDP_RST_PTR_BYTE = 8'h00;
  localparam logic [7:0] FWDP_RST_PCTRL    = 8'h00;
  localparam logic [3:0] FWDP_RST_WAIT     = 4'h7;

  // ***********************************************************
  // field positions
  // ***********************************************************
  localparam int unsigned FWDP_WAIT_W       = 4;
  localparam int unsigned FWDP_PCTRL_SEL    = 0;
  localparam int unsigned FWDP_PCTRL_TOGGLE = 5;
  localparam int unsigned FWDP_PCTRL_DIR0   = 6;
  localparam int unsigned FWDP_PCTRL_DIR1   = 7;

endpackage

// ===== tb/fwdp_core_model.sv
`timescale 1ns/1ps
// ***
// core and flash stand-in
// ***
module fwdp_core_model (
  // clock
  input wire logic clk,
  // fetch progress
  input wire logic fetch_stall,
  input wire logic fetch_data_valid,
  // requests to the block
  output logic     fetch_start,
  output logic     ptr_step_req,
  output logic     ptr_use_done
);
  // idle until the bench asks
  initial begin
    fetch_start = 1'b0;
    ptr_step_req = 1'b0;
    ptr_use_done = 1'b0;
  end
  // one fetch; flash data taken only with valid, stalled cycles counted
  task automatic fetch(output int n);
    n = 0;
    @(posedge clk);
    fetch_start <= 1'b1;
    @(posedge clk);
    fetch_start <= 1'b0;
    // look mid-cycle, where stall and valid have settled
    do begin
      @(negedge clk);
      n += int'(fetch_stall === 1'b1);
    end while (fetch_data_valid !== 1'b1 && n < 40);
    @(posedge clk);
  endtask
  // one-cycle pointer events, result visible when task returns
  task automatic pulse(input logic s, input logic u);
    @(posedge clk);
    ptr_step_req <= s;
    ptr_use_done <= u;
    @(posedge clk);
    ptr_step_req <= 1'b0;
    ptr_use_done <= 1'b0;
    @(posedge clk);
  endtask
endmodule

// ===== tb/fwdp_properties.sv
`timescale 1ns/1ps
// ***
// port checks
// ***
module fwdp_properties (
  // clock and reset
  input wire logic        clk,
  input wire logic        reset_n,
  // bus handshake
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic        avs_waitrequest,
  // fetch and pointer events
  input wire logic        fetch_start,
  input wire logic        fetch_stall,
  input wire logic        fetch_data_valid,
  input wire logic        ptr_step_req,
  input wire logic        ptr_use_done,
  // move address
  input wire logic [23:0] xdata_addr,
  input wire logic [15:0] xram_index,
  input wire logic        active_sel
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  // fetch steps: taken, then released
  sequence s_take; fetch_start && !fetch_stall; endsequence
  sequence s_release; fetch_stall ##1 !fetch_stall; endsequence
  // a write lands only at the edge where waitrequest is low
  logic wr_done;
  assign wr_done = avs_write && !avs_waitrequest;
  a_bus_answer: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("bus request not answered");
  a_bus_single: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low too long");
  a_index_low: assert property (xram_index == xdata_addr[15:0])
    else $error("top byte changed location");
  a_fetch_take: assert property (s_take |=> fetch_stall)
    else $error("fetch not stalled");
  a_valid_fall: assert property (s_release |-> fetch_data_valid)
    else $error("no valid at stall end");
  a_valid_only: assert property (fetch_data_valid |-> $fell(fetch_stall))
    else $error("valid without stall end");
  a_stall_bound: assert property ($rose(fetch_stall) |-> ##[1:16] !fetch_stall)
    else $error("stall longer than 16");
  a_sel_hold: assert property (!ptr_use_done && !wr_done |=> $stable(active_sel))
    else $error("selection moved by itself");
  a_addr_hold: assert property (!ptr_step_req && !ptr_use_done && !wr_done |=> $stable(xdata_addr))
    else $error("move address moved by itself");
endmodule

// ===== tb/fwdp_top_tb.sv
`timescale 1ns/1ps
module fwdp_top_tb;
  import fwdp_pkg::*;
  // ***
  // signals and tables
  // ***
  logic                   clk = 1'b0;
  logic                   reset_n = 1'b0;
  logic [FWDP_ADDR_W-1:0] avs_address = '0;
  logic                   avs_read = 1'b0;
  logic                   avs_write = 1'b0;
  logic [FWDP_DATA_W-1:0] avs_writedata = '0;
  logic [3:0]             avs_byteenable = 4'h1;
  logic [FWDP_DATA_W-1:0] avs_readdata, v;
  logic                   avs_waitrequest, fetch_start, fetch_stall, fetch_data_valid;
  logic                   ptr_step_req, ptr_use_done, active_sel;
  logic [23:0]            xdata_addr;
  logic [15:0]            xram_index;
  int                     n_fail = 0, n_checks = 0, cyc = 0, n;
  logic [7:0]             ix_t [8] = '{8'h82, 8'h83, 8'h84, 8'h85, 8'h86, 8'h92, 8'h93, 8'h95};
  logic [7:0]             rs_t [8] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h07, 8'h00, 8'h00};
  logic [7:0]             mk_t [8] = '{8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hE1, 8'h0F, 8'hFF, 8'hFF};
  logic [7:0]             pv_t [8] = '{8'h34, 8'h12, 8'h00, 8'h00, 8'h00, 8'h00, 8'hAB, 8'hCD};
  logic [7:0]             w_t [4] = '{8'h00, 8'h01, 8'h07, 8'h0F};
  logic [7:0]             c_t [4] = '{8'h00, 8'h41, 8'h81, 8'h40};
  logic [23:0]            a_t [4] = '{24'hAB1235, 24'hCD0001, 24'hCD0000, 24'hAB1234};
  always #20 clk = ~clk;
  fwdp_top dut (.clk, .reset_n, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable,
    .avs_readdata, .avs_waitrequest, .fetch_start, .fetch_stall, .fetch_data_valid, .ptr_step_req,
    .ptr_use_done, .xdata_addr, .xram_index, .active_sel);
  fwdp_core_model core (.clk, .fetch_stall, .fetch_data_valid, .fetch_start, .ptr_step_req, .ptr_use_done);
  // ***
  // tasks
  // ***
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // request held until waitrequest is sampled low
  task automatic bus(input logic rd, input logic [7:0] idx, input logic [7:0] d);
    @(posedge clk);
    avs_address <= {idx, 2'b00};
    avs_writedata <= {24'h000000, d};
    avs_read <= rd;
    avs_write <= !rd;
    // waitrequest looked at mid-cycle; the next rising edge is the one that samples it low
    do @(negedge clk); while (avs_waitrequest !== 1'b0);
    @(posedge clk);
    v = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task automatic rdchk(input logic [7:0] idx, input logic [7:0] exp);
    bus(1'b1, idx, 8'h00);
    check(v, {24'h000000, exp});
  endtask
  task automatic results;
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // hang guard, far above the few hundred cycles needed
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      n_fail++;
      results();
    end
  end
  // ***
  // tests
  // ***
  initial begin
    repeat (12) @(posedge clk);
    reset_n <= 1'b1;
    for (int i = 0; i < 8; i++) rdchk(ix_t[i], rs_t[i]);
    rdchk(8'h90, 8'h00);
    for (int i = 0; i < 8; i++) begin
      bus(1'b0, ix_t[i], 8'hFF);
      rdchk(ix_t[i], mk_t[i]);
    end
    $display("test registers done");
    foreach (w_t[i]) begin
      bus(1'b0, FWDP_IDX_WAIT, w_t[i]);
      core.fetch(n);
      check(n, w_t[i] + 1);
    end
    avs_byteenable <= 4'h0;
    bus(1'b0, FWDP_IDX_WAIT, 8'h03);
    avs_byteenable <= 4'h1;
    core.fetch(n);
    check(n, 16);
    bus(1'b0, FWDP_IDX_WAIT, 8'h02);
    core.fetch(n);
    check(n, 3);
    $display("test fetch done");
    for (int i = 0; i < 8; i++) if (i != 4 && i != 5) bus(1'b0, ix_t[i], pv_t[i]);
    foreach (c_t[i]) begin
      bus(1'b0, FWDP_IDX_PCTRL, c_t[i]);
      core.pulse(1'b1, 1'b0);
      check(xdata_addr, a_t[i]);
      check(xram_index, a_t[i][15:0]);
    end
    $display("test pointers done");
    bus(1'b0, FWDP_IDX_PCTRL, 8'h20);
    core.pulse(1'b0, 1'b1);
    check(active_sel, 1'b1);
    rdchk(FWDP_IDX_PCTRL, 8'h21);
    check(xdata_addr, 24'hCD0000);
    core.pulse(1'b1, 1'b1);
    check(xdata_addr, 24'hAB1234);
    rdchk(FWDP_IDX_P1_LOW, 8'h01);
    check(fetch_stall, 1'b0);
    $display("test toggle done");
    results();
  end
endmodule
bind fwdp_top fwdp_properties chk (.clk, .reset_n, .avs_read, .avs_write, .avs_waitrequest, .fetch_start,
  .fetch_stall, .fetch_data_valid, .ptr_step_req, .ptr_use_done, .xdata_addr, .xram_index, .active_sel);

// ===== verilog/fwdp_fetch_wait.sv
`timescale 1ns/1ps

// ***********************************************************
// program fetch stretcher
// ***********************************************************
module fwdp_fetch_wait
  import fwdp_pkg::*;
#(
  parameter int unsigned WAIT_W = FWDP_WAIT_W
) (
  // clock and reset
  input  wire logic              clk,
  input  wire logic              reset_n,
  // fetch request and setting
  input  wire logic              start,
  input  wire logic [WAIT_W-1:0] wait_states,
  // fetch progress
  output logic                   busy,
  output logic                   done
);

  typedef struct packed {
    logic              busy;
    logic              done;
    logic [WAIT_W-1:0] cnt;
  } fwdp_fw_state_t;

  fwdp_fw_state_t st_r;
  fwdp_fw_state_t st_nxt;

  // count down field value, then release: field + 1 busy cycles
  always_comb begin
    st_nxt      = st_r;
    st_nxt.done = 1'b0;
    if (st_r.busy) begin
      if (st_r.cnt == '0) begin
        st_nxt.busy = 1'b0;
        st_nxt.done = 1'b1;
      end else begin
        st_nxt.cnt = st_r.cnt - WAIT_W'(1);
      end
    end else if (start) begin
      st_nxt.busy = 1'b1;
      st_nxt.cnt  = wait_states;
    end
  end

  // state register
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign busy = st_r.busy;
  assign done = st_r.done;

endmodule

// ===== verilog/fwdp_top.sv
// Register access over Avalon-MM was decided locally.
`timescale 1ns/1ps

// Notes on behaviour
// - wait field plus one cycles per fetch
// - wait states stretch program fetches only
// - wait register resets to 0x07
// - select bit picks first or second pointer
// - step direction bit per pointer, 1 decrements
// - auto toggle flips selection after pointer use
// - select bit reads current selection
// - pointer bytes at 0x82 to 0x85
// - each pointer owns a top byte
// - top byte never changes on-chip location
// - control and pointer bytes reset to zero
// - move address low 16 from active pointer
// - move address bits 23:16 from active top

// ***********************************************************
// fetch wait states and dual data pointer unit
// ***********************************************************
module fwdp_top
  import fwdp_pkg::*;
(
  // clock and reset
  input  wire logic                   clk,
  input  wire logic                   reset_n,
  // register bus slave
  input  wire logic [FWDP_ADDR_W-1:0] avs_address,
  input  wire logic                   avs_read,
  input  wire logic                   avs_write,
  input  wire logic [FWDP_DATA_W-1:0] avs_writedata,
  input  wire logic [3:0]             avs_byteenable,
  output logic [FWDP_DATA_W-1:0]      avs_readdata,
  output logic                        avs_waitrequest,
  // program fetch from flash
  input  wire logic                   fetch_start,
  output logic                        fetch_stall,
  output logic                        fetch_data_valid,
  // pointer events from the core
  input  wire logic                   ptr_step_req,
  input  wire logic                   ptr_use_done,
  // external data move address
  output logic [23:0]                 xdata_addr,
  output logic [15:0]                 xram_index,
  output logic                        active_sel
);

  // ***********************************************************
  // state
  // ***********************************************************
  typedef struct packed {
    logic [15:0]            ptr0;
    logic [15:0]            ptr1;
    logic [7:0]             top0;
    logic [7:0]             top1;
    logic                   sel;
    logic                   toggle;
    logic [1:0]             dir;
    logic [FWDP_WAIT_W-1:0] wait_states;
    logic                   wait_req;
    logic [FWDP_DATA_W-1:0] rdata;
    logic [23:0]            xaddr;
    logic [15:0]            xidx;
  } fwdp_state_t;

  fwdp_state_t st_r;
  fwdp_state_t st_nxt;

  // ***********************************************************
  // helpers
  // ***********************************************************

  // one step of a pointer, up or down, wrapping at 16 bits
  function automatic logic [15:0] fwdp_step(input logic [15:0] p, input logic dec);
    logic [15:0] r;
    r = dec ? (p - 16'h0001) : (p + 16'h0001);
    return r;
  endfunction

  // index from a byte address; misaligned is unmapped
  function automatic logic [7:0] fwdp_index(input logic [FWDP_ADDR_W-1:0] a);
    logic [7:0] r;
    r = (a[1:0] == 2'h0) ? a[9:2] : 8'hFF;
    return r;
  endfunction

  // ***********************************************************
  // fetch stretcher
  // ***********************************************************

  // data accesses never enter here, only program fetches
  fwdp_fetch_wait #(
    .WAIT_W      (FWDP_WAIT_W)
  ) u_fetch_wait (
    .clk         (clk),
    .reset_n     (reset_n),
    .start       (fetch_start),
    .wait_states (st_r.wait_states),
    .busy        (fetch_stall),
    .done        (fetch_data_valid)
  );

  // ***********************************************************
  // next state
  // ***********************************************************
  logic [7:0] idx;
  logic       acc_now;
  logic       wr_now;
  logic       rd_now;
  logic       wr_lane;
  logic [7:0] wbyte;
  logic       sel_eff;

  // a write is served at the edge where waitrequest is low; read data is captured at the edge before, where it is high
  assign idx     = fwdp_index(avs_address);
  assign acc_now = (avs_read | avs_write) & ~st_r.wait_req;
  assign wr_now  = avs_write & ~st_r.wait_req;
  assign rd_now  = avs_read & st_r.wait_req;
  assign wr_lane = wr_now & avs_byteenable[0];
  assign wbyte   = avs_writedata[7:0];

  always_comb begin
    st_nxt = st_r;

    // one wait cycle, then a single answer cycle
    if (st_r.wait_req) begin
      st_nxt.wait_req = ~(avs_read | avs_write);
    end else begin
      st_nxt.wait_req = 1'b1;
    end

    // read data captured as waitrequest drops
    if (rd_now) begin
      st_nxt.rdata = '0;
      unique case (idx)
        FWDP_IDX_P0_LOW:  st_nxt.rdata[7:0] = st_r.ptr0[7:0];
        FWDP_IDX_P0_HIGH: st_nxt.rdata[7:0] = st_r.ptr0[15:8];
        FWDP_IDX_P1_LOW:  st_nxt.rdata[7:0] = st_r.ptr1[7:0];
        FWDP_IDX_P1_HIGH: st_nxt.rdata[7:0] = st_r.ptr1[15:8];
        FWDP_IDX_P0_TOP:  st_nxt.rdata[7:0] = st_r.top0;
        FWDP_IDX_P1_TOP:  st_nxt.rdata[7:0] = st_r.top1;
        FWDP_IDX_PCTRL: begin
          st_nxt.rdata[FWDP_PCTRL_DIR1]   = st_r.dir[1];
          st_nxt.rdata[FWDP_PCTRL_DIR0]   = st_r.dir[0];
          st_nxt.rdata[FWDP_PCTRL_TOGGLE] = st_r.toggle;
          st_nxt.rdata[FWDP_PCTRL_SEL]    = st_r.sel;
        end
        FWDP_IDX_WAIT: begin
          st_nxt.rdata[FWDP_WAIT_W-1:0] = st_r.wait_states;
        end
        default: st_nxt.rdata = '0;
      endcase
    end

    // software writes; only the low byte lane carries data
    if (wr_lane) begin
      unique case (idx)
        FWDP_IDX_P0_LOW:  st_nxt.ptr0[7:0]  = wbyte;
        FWDP_IDX_P0_HIGH: st_nxt.ptr0[15:8] = wbyte;
        FWDP_IDX_P1_LOW:  st_nxt.ptr1[7:0]  = wbyte;
        FWDP_IDX_P1_HIGH: st_nxt.ptr1[15:8] = wbyte;
        FWDP_IDX_P0_TOP:  st_nxt.top0       = wbyte;
        FWDP_IDX_P1_TOP:  st_nxt.top1       = wbyte;
        FWDP_IDX_PCTRL: begin
          st_nxt.dir    = {wbyte[FWDP_PCTRL_DIR1], wbyte[FWDP_PCTRL_DIR0]};
          st_nxt.toggle = wbyte[FWDP_PCTRL_TOGGLE];
          st_nxt.sel    = wbyte[FWDP_PCTRL_SEL];
        end
        FWDP_IDX_WAIT: begin
          st_nxt.wait_states = wbyte[FWDP_WAIT_W-1:0];
        end
        default: st_nxt.wait_states = st_nxt.wait_states;
      endcase
    end

    // step the selected pointer; a same-cycle byte write wins
    if (ptr_step_req) begin
      if (st_r.sel) begin
        if (!(wr_lane && (idx == FWDP_IDX_P1_LOW || idx == FWDP_IDX_P1_HIGH))) begin
          st_nxt.ptr1 = fwdp_step(st_r.ptr1, st_r.dir[1]);
        end
      end else begin
        if (!(wr_lane && (idx == FWDP_IDX_P0_LOW || idx == FWDP_IDX_P0_HIGH))) begin
          st_nxt.ptr0 = fwdp_step(st_r.ptr0, st_r.dir[0]);
        end
      end
    end

    // toggle acts on top of any written select value
    if (ptr_use_done && st_nxt.toggle) begin
      st_nxt.sel = ~st_nxt.sel;
    end

    // move address follows the selection now in force
    sel_eff = st_nxt.sel;
    if (sel_eff) begin
      st_nxt.xaddr = {st_nxt.top1, st_nxt.ptr1};
    end else begin
      st_nxt.xaddr = {st_nxt.top0, st_nxt.ptr0};
    end

    // on-chip memory sees only the low 16 bits
    st_nxt.xidx = st_nxt.xaddr[15:0];
  end

  // ***********************************************************
  // state register
  // ***********************************************************

  // everything clears except the wait setting and waitrequest, which resets high
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      st_r             <= '0;
      st_r.ptr0        <= {FWDP_RST_PTR_BYTE, FWDP_RST_PTR_BYTE};
      st_r.ptr1        <= {FWDP_RST_PTR_BYTE, FWDP_RST_PTR_BYTE};
      st_r.top0        <= FWDP_RST_PTR_BYTE;
      st_r.top1        <= FWDP_RST_PTR_BYTE;
      st_r.sel         <= FWDP_RST_PCTRL[FWDP_PCTRL_SEL];
      st_r.toggle      <= FWDP_RST_PCTRL[FWDP_PCTRL_TOGGLE];
      st_r.dir         <= FWDP_RST_PCTRL[FWDP_PCTRL_DIR1:FWDP_PCTRL_DIR0];
      st_r.wait_states <= FWDP_RST_WAIT;
      st_r.wait_req    <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ***********************************************************
  // outputs
  // ***********************************************************
  assign avs_readdata    = st_r.rdata;
  assign avs_waitrequest = st_r.wait_req;
  assign xdata_addr      = st_r.xaddr;
  assign xram_index      = st_r.xidx;
  assign active_sel      = st_r.sel;

  // acc_now is kept for symmetry of decode; unused lanes ignored
  logic unused_ok;
  assign unused_ok = acc_now & (|avs_writedata[31:8]) & (|avs_byteenable[3:1]);

endmodule
